// ==== core/flash_host_map.svh ====
// Register map, opcodes, field positions and timing counts of the flash host controller.
// Assumes a 100 MHz system clock and a serial flash in mode 0 (clock idles low).
`ifndef FLASH_HOST_MAP_SVH
`define FLASH_HOST_MAP_SVH

`define REG_CMD             8'h00
`define REG_ADDR            8'h04
`define REG_LEN             8'h08
`define REG_WDATA           8'h0c
`define REG_RDATA           8'h10
`define REG_STATUS          8'h14

`define CMD_QUAD_BIT        8
`define CMD_POLL_BIT        9
`define CMD_CFG_BIT         10

`define ST_ACTIVE_BIT       0
`define ST_REFUSED_BIT      1
`define ST_SUSPENDED_BIT    2
`define ST_GAP_BIT          3
`define ST_DEV_BUSY_BIT     4

`define IDENTIFICATION_READ 8'haf
`define PARAM_READ          8'h5a
`define SECTOR_ERASE        8'h20
`define BLOCK32_ERASE       8'h52
`define BLOCK64_ERASE       8'hd8
`define CHIP_ERASE_A        8'hc7
`define CHIP_ERASE_B        8'h60
`define PAGE_PROG           8'h02
`define QUAD_PAGE_PROG      8'h32
`define WRITE_SUSPEND       8'hb0
`define WRITE_RESUME        8'h30
`define WRITE_LATCH_SET_CMD 8'h06
`define STATUS_READ         8'h05

`define DEV_BUSY_BIT        0
`define ID_BYTES            9'h003
`define PAGE_BYTES          9'h100
`define SECTOR_LSB          12
`define BLOCK32_LSB         15
`define BLOCK64_LSB         16
`define TOP_ADDRESS_BIT     23

`define CLK_MHZ             100
`define SUSPEND_GAP_US      500
`define SCK_HALF_CYC        3'h4
`define CS_GAP_CYC          3'h7

`endif

// ==== core/flash_host_pkg.sv ====
// Types shared by the flash host controller.
// Assumes nothing beyond the map header for its users.
package flash_host_pkg;

  typedef enum logic [2:0] {S_IDLE, S_START, S_FRAME, S_TAIL, S_GAP} state_t;

  typedef enum logic [1:0] {FK_LATCH, FK_MAIN, FK_POLL} frame_kind_t;

endpackage

// ==== core/flash_host.sv ====
// Host controller for a serial NOR flash: APB register slave, command framer, pin driver.
// Assumes mode-0 flash pins wired by the bench (sio wires resolved from sio_oe).
`include "flash_host_map.svh"

////////////////////////////////////////////////////////////////////////////////
module flash_host #(
  parameter int SUSP_GAP_CYC = `SUSPEND_GAP_US * `CLK_MHZ
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             cs_n,
  output logic             sclk,
  output logic      [3:0]  sio_out,
  output logic      [3:0]  sio_oe,
  input  wire logic [3:0]  sio_in
);

  flash_host_pkg::state_t      state;
  flash_host_pkg::frame_kind_t kind;

  logic [7:0]  op;
  logic        quad_cmd;
  logic        poll_en;
  logic        quad_io_config_bit;
  logic [23:0] addr;
  logic [8:0]  len;
  logic [7:0]  wbuf [0:255];
  logic [7:0]  wptr;
  logic [31:0] rx;
  logic        refused;
  logic        erase_suspended_flag;
  logic        chip_open;
  logic        dev_busy;
  logic        susp_erase;
  logic [23:0] susp_base;
  logic [23:0] susp_mask;
  logic        wr_erase;
  logic [23:0] wr_base;
  logic [23:0] wr_mask;
  logic [15:0] susp_timer;
  logic [11:0] pos;
  logic [2:0]  hc;
  logic [3:0]  sio_meta;
  logic [3:0]  sio_sync;
  logic        write_latch_set_cmd_done;

  logic        wr_access;
  logic        cmd_go;
  logic        go_ok;
  logic [7:0]  new_op;
  logic [7:0]  f_op;
  logic        f_quad;
  logic        f_quad_ad;
  logic        f_addr;
  logic        f_read;
  logic [11:0] f_dum;
  logic [8:0]  f_bytes;
  logic [11:0] e_op;
  logic [11:0] e_addr;
  logic [11:0] e_dum;
  logic [11:0] e_end;
  logic [11:0] q;
  logic [11:0] rel;
  logic [11:0] bi;
  logic [7:0]  dbyte;
  logic [2:0]  k;
  logic        nquad;
  logic        drv_en;
  logic [3:0]  drv_nib;
  logic [3:0]  drv_oe;
  logic        rise_now;
  logic        fall_now;
  logic        needs_poll;
  logic [23:0] mask_new;

  function automatic logic is_write_op(input logic [7:0] o);
    return o == `SECTOR_ERASE || o == `BLOCK32_ERASE || o == `BLOCK64_ERASE ||
           o == `CHIP_ERASE_A || o == `CHIP_ERASE_B || o == `PAGE_PROG ||
           o == `QUAD_PAGE_PROG;
  endfunction

  function automatic logic is_prog(input logic [7:0] o);
    return o == `PAGE_PROG || o == `QUAD_PAGE_PROG;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state so that read data leave a flip-flop

  assign wr_access = psel && penable && pready && pwrite;
  assign cmd_go    = wr_access && paddr == `REG_CMD;
  assign new_op    = pwdata[7:0];

  always_comb
  begin
    go_ok = (state == flash_host_pkg::S_IDLE);
    if (is_prog(new_op))
    begin
      if (len == 9'h000 || len > `PAGE_BYTES)
        go_ok = 1'b0;
      if (erase_suspended_flag && susp_erase && (addr & susp_mask) == susp_base)
        go_ok = 1'b0;
    end
    if (new_op == `QUAD_PAGE_PROG && !pwdata[`CMD_CFG_BIT])
      go_ok = 1'b0;
    if ((new_op == `CHIP_ERASE_A || new_op == `CHIP_ERASE_B) && erase_suspended_flag)
      go_ok = 1'b0;
    if (new_op == `WRITE_SUSPEND && (erase_suspended_flag || chip_open || susp_timer != 16'h0000))
      go_ok = 1'b0;
    if (new_op == `WRITE_RESUME && !erase_suspended_flag)
      go_ok = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else if (psel && penable && !pready)
    begin
      pready  <= 1'b1;
      pslverr <= !(paddr inside {`REG_CMD, `REG_ADDR, `REG_LEN, `REG_WDATA,
                                 `REG_RDATA, `REG_STATUS});
      unique case (paddr)
        `REG_CMD:    prdata <= {21'h0, quad_io_config_bit, poll_en, quad_cmd, op};
        `REG_ADDR:   prdata <= {8'h00, addr};
        `REG_LEN:    prdata <= {23'h0, len};
        `REG_WDATA:  prdata <= {24'h0, wptr};
        `REG_RDATA:  prdata <= rx;
        `REG_STATUS: prdata <= {27'h0, dev_busy, susp_timer != 16'h0000,
                                erase_suspended_flag, refused,
                                state != flash_host_pkg::S_IDLE};
        default:     prdata <= 32'h0000_0000;
      endcase
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Command registers change only while idle so a running frame never sees them move
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      op                 <= 8'h00;
      quad_cmd           <= 1'b0;
      poll_en            <= 1'b0;
      quad_io_config_bit <= 1'b0;
      addr               <= 24'h00_0000;
      len                <= 9'h000;
      refused            <= 1'b0;
    end
    else if (wr_access && state == flash_host_pkg::S_IDLE)
    begin
      if (cmd_go)
      begin
        refused <= !go_ok;
        if (go_ok)
        begin
          op                 <= new_op;
          quad_cmd           <= pwdata[`CMD_QUAD_BIT];
          poll_en            <= pwdata[`CMD_POLL_BIT];
          quad_io_config_bit <= pwdata[`CMD_CFG_BIT];
        end
      end
      if (paddr == `REG_ADDR)
        addr <= pwdata[23:0];
      if (paddr == `REG_LEN)
        len <= pwdata[8:0];
    end
  end

  // Page data staged by software; it must already read back as all ones on the flash
  always_ff @(posedge clk)
  begin
    if (!nrst)
      wptr <= 8'h00;
    else if (cmd_go && go_ok)
      wptr <= 8'h00;
    else if (wr_access && paddr == `REG_WDATA && state == flash_host_pkg::S_IDLE)
      wptr <= wptr + 8'h01;
  end

  always_ff @(posedge clk)
  begin
    if (wr_access && paddr == `REG_WDATA && state == flash_host_pkg::S_IDLE)
      wbuf[wptr] <= pwdata[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Frame shape for the current frame kind

  always_comb
  begin
    f_op      = (kind == flash_host_pkg::FK_LATCH) ? `WRITE_LATCH_SET_CMD :
                (kind == flash_host_pkg::FK_POLL) ? `STATUS_READ : op;
    f_quad    = quad_cmd || (kind == flash_host_pkg::FK_MAIN && op == `IDENTIFICATION_READ);
    f_quad_ad = f_quad || (kind == flash_host_pkg::FK_MAIN && op == `QUAD_PAGE_PROG);
    f_addr    = kind == flash_host_pkg::FK_MAIN &&
                op inside {`PARAM_READ, `SECTOR_ERASE, `BLOCK32_ERASE, `BLOCK64_ERASE,
                           `PAGE_PROG, `QUAD_PAGE_PROG};
    f_read    = kind == flash_host_pkg::FK_POLL || (kind == flash_host_pkg::FK_MAIN &&
                op inside {`IDENTIFICATION_READ, `PARAM_READ});
    f_dum     = 12'h000;
    f_bytes   = 9'h000;
    if (kind == flash_host_pkg::FK_POLL)
    begin
      f_bytes = 9'h001;
      f_dum   = f_quad ? 12'h002 : 12'h000;
    end
    else if (kind == flash_host_pkg::FK_MAIN)
    begin
      if (op == `IDENTIFICATION_READ)
      begin
        f_bytes = `ID_BYTES;
        f_dum   = 12'h002;
      end
      else if (op == `PARAM_READ)
      begin
        f_bytes = len;
        f_dum   = f_quad ? 12'h002 : 12'h008;
      end
      else if (is_prog(op))
        f_bytes = len;
    end
    e_op   = f_quad ? 12'h002 : 12'h008;
    e_addr = e_op + (f_addr ? (f_quad_ad ? 12'h006 : 12'h018) : 12'h000);
    e_dum  = e_addr + f_dum;
    e_end  = e_dum + (12'(f_bytes) << (f_quad_ad ? 1 : 3));
  end

  // Pin values for the clock about to start
  always_comb
  begin
    q      = (state == flash_host_pkg::S_START) ? 12'h000 : pos + 12'h001;
    rel    = 12'h000;
    bi     = 12'h000;
    dbyte  = 8'h00;
    k      = q[2:0];
    nquad  = f_quad;
    drv_en = 1'b1;
    if (q < e_op)
      dbyte = f_op;
    else if (q < e_addr)
    begin
      rel   = q - e_op;
      nquad = f_quad_ad;
      bi    = f_quad_ad ? rel >> 1 : rel >> 3;
      k     = rel[2:0];
      unique case (bi[1:0])
        2'h0:    dbyte = addr[`TOP_ADDRESS_BIT -: 8];
        2'h1:    dbyte = addr[15:8];
        default: dbyte = addr[7:0];
      endcase
    end
    else if (q < e_dum)
    begin
      nquad  = f_quad_ad;
      drv_en = !f_quad_ad;
    end
    else
    begin
      rel    = q - e_dum;
      nquad  = f_quad_ad;
      bi     = f_quad_ad ? rel >> 1 : rel >> 3;
      k      = rel[2:0];
      dbyte  = f_read ? 8'h00 : wbuf[bi[7:0]];
      drv_en = !f_read;
    end
    drv_nib = nquad ? (k[0] ? dbyte[3:0] : dbyte[7:4]) : {3'b000, dbyte[3'h7 - k]};
    drv_oe  = !drv_en ? 4'h0 : (nquad ? 4'hf : 4'h1);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link sequencer: clock divider, chip select, shifting

  assign rise_now   = state == flash_host_pkg::S_FRAME && hc == 3'h0 && !sclk;
  assign fall_now   = state == flash_host_pkg::S_FRAME && hc == 3'h0 && sclk;
  assign needs_poll = poll_en && (is_write_op(op) || op == `WRITE_SUSPEND ||
                                  op == `WRITE_RESUME);
  assign mask_new   = (op == `SECTOR_ERASE) ? (24'hff_ffff << `SECTOR_LSB) :
                      (op == `BLOCK32_ERASE) ? (24'hff_ffff << `BLOCK32_LSB) :
                      (24'hff_ffff << `BLOCK64_LSB);

  always_ff @(posedge clk)
  begin
    sio_meta <= sio_in;
    sio_sync <= sio_meta;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
      rx <= 32'h0000_0000;
    else if (rise_now && f_read && pos >= e_dum)
      rx <= f_quad_ad ? {rx[27:0], sio_sync} : {rx[30:0], sio_sync[1]};
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      state     <= flash_host_pkg::S_IDLE;
      kind      <= flash_host_pkg::FK_MAIN;
      cs_n      <= 1'b1;
      sclk      <= 1'b0;
      sio_out   <= 4'h0;
      sio_oe    <= 4'h0;
      pos       <= 12'h000;
      hc        <= 3'h0;
      write_latch_set_cmd_done <= 1'b0;
    end
    else
    begin
      unique case (state)
        flash_host_pkg::S_IDLE:
          if (cmd_go && go_ok)
          begin
            kind  <= is_write_op(new_op) ? flash_host_pkg::FK_LATCH :
                                           flash_host_pkg::FK_MAIN;
            state <= flash_host_pkg::S_START;
          end
        flash_host_pkg::S_START:
        begin
          cs_n    <= 1'b0;
          sclk    <= 1'b0;
          sio_out <= drv_nib;
          sio_oe  <= drv_oe;
          pos     <= 12'h000;
          hc      <= `SCK_HALF_CYC - 3'h1;
          state   <= flash_host_pkg::S_FRAME;
          if (kind == flash_host_pkg::FK_MAIN)
            write_latch_set_cmd_done <= 1'b0;
        end
        flash_host_pkg::S_FRAME:
          if (hc != 3'h0)
            hc <= hc - 3'h1;
          else if (!sclk)
          begin
            sclk <= 1'b1;
            hc   <= `SCK_HALF_CYC - 3'h1;
          end
          else
          begin
            sclk <= 1'b0;
            hc   <= `SCK_HALF_CYC - 3'h1;
            if (pos + 12'h001 == e_end)
            begin
              sio_oe <= 4'h0;
              state  <= flash_host_pkg::S_TAIL;
            end
            else
            begin
              pos     <= pos + 12'h001;
              sio_out <= drv_nib;
              sio_oe  <= drv_oe;
            end
          end
        flash_host_pkg::S_TAIL:
          if (hc != 3'h0)
            hc <= hc - 3'h1;
          else
          begin
            cs_n  <= 1'b1;
            hc    <= `CS_GAP_CYC;
            state <= flash_host_pkg::S_GAP;
            if (kind == flash_host_pkg::FK_LATCH)
              write_latch_set_cmd_done <= 1'b1;
          end
        flash_host_pkg::S_GAP:
          if (hc != 3'h0)
            hc <= hc - 3'h1;
          else if (kind == flash_host_pkg::FK_LATCH)
          begin
            kind  <= flash_host_pkg::FK_MAIN;
            state <= flash_host_pkg::S_START;
          end
          else if ((kind == flash_host_pkg::FK_MAIN && needs_poll) ||
                   (kind == flash_host_pkg::FK_POLL && rx[`DEV_BUSY_BIT]))
          begin
            kind  <= flash_host_pkg::FK_POLL;
            state <= flash_host_pkg::S_START;
          end
          else
            state <= flash_host_pkg::S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Suspend bookkeeping, kept from what this host has sent and seen

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      erase_suspended_flag <= 1'b0;
      susp_erase           <= 1'b0;
      susp_base            <= 24'h00_0000;
      susp_mask            <= 24'h00_0000;
      wr_erase             <= 1'b0;
      wr_base              <= 24'h00_0000;
      wr_mask              <= 24'h00_0000;
      chip_open            <= 1'b0;
      dev_busy             <= 1'b0;
      susp_timer           <= 16'h0000;
    end
    else
    begin
      if (state == flash_host_pkg::S_START && kind == flash_host_pkg::FK_MAIN &&
          op == `WRITE_SUSPEND)
        susp_timer <= 16'(SUSP_GAP_CYC);
      else if (susp_timer != 16'h0000)
        susp_timer <= susp_timer - 16'h0001;
      if (state == flash_host_pkg::S_TAIL && hc == 3'h0)
      begin
        if (kind == flash_host_pkg::FK_POLL)
        begin
          dev_busy <= rx[`DEV_BUSY_BIT];
          if (!rx[`DEV_BUSY_BIT])
            chip_open <= 1'b0;
        end
        else if (kind == flash_host_pkg::FK_MAIN)
        begin
          if (op == `CHIP_ERASE_A || op == `CHIP_ERASE_B)
            chip_open <= 1'b1;
          if (op inside {`SECTOR_ERASE, `BLOCK32_ERASE, `BLOCK64_ERASE})
          begin
            wr_erase <= 1'b1;
            wr_mask  <= mask_new;
            wr_base  <= addr & mask_new;
          end
          else if (is_prog(op))
            wr_erase <= 1'b0;
          if (op == `WRITE_SUSPEND)
          begin
            erase_suspended_flag <= 1'b1;
            susp_erase           <= wr_erase;
            susp_base            <= wr_base;
            susp_mask            <= wr_mask;
          end
          else if (op == `WRITE_RESUME)
            erase_suspended_flag <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence main_start;
    state == flash_host_pkg::S_START && kind == flash_host_pkg::FK_MAIN;
  endsequence

  sequence write_frame_ends;
    state == flash_host_pkg::S_TAIL && kind == flash_host_pkg::FK_MAIN && needs_poll;
  endsequence

  sequence poll_frame_starts;
    state == flash_host_pkg::S_START && kind == flash_host_pkg::FK_POLL;
  endsequence

  AST_LATCH_FIRST: assert property (main_start and is_write_op(op) |-> write_latch_set_cmd_done)
    else $error("erase or program sent without a preceding latch frame");

  AST_SELECT_LOW: assert property (state == flash_host_pkg::S_FRAME |-> !cs_n)
    else $error("chip select rose inside a frame");

  AST_ID_QUAD: assert property (main_start and op == `IDENTIFICATION_READ
                                |-> f_quad && e_dum == 12'h004 && e_end == 12'h00a)
    else $error("identification read frame has the wrong shape");

  AST_SCK_HALF: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("serial clock high phase is not four cycles");

  AST_READ_RELEASE: assert property (state == flash_host_pkg::S_FRAME && f_read
                                     && pos >= e_dum |-> sio_oe == 4'h0)
    else $error("host drives data lines while the flash answers");

  AST_SUSPEND_GAP: assert property (main_start and op == `WRITE_SUSPEND
                                    |-> $past(susp_timer) == 16'h0000 ##1
                                        susp_timer == 16'(SUSP_GAP_CYC))
    else $error("suspends closer than the minimum spacing");

  AST_ONE_SUSPEND: assert property (main_start and op == `WRITE_SUSPEND
                                    |-> !erase_suspended_flag && !chip_open)
    else $error("suspend sent while suspended or during chip erase");

  AST_NO_CHIP_SUSP: assert property (main_start and (op == `CHIP_ERASE_A ||
                                     op == `CHIP_ERASE_B) |-> !erase_suspended_flag)
    else $error("chip erase sent while a write is suspended");

  AST_QUAD_CFG: assert property (main_start and op == `QUAD_PAGE_PROG
                                 |-> quad_io_config_bit && f_quad_ad)
    else $error("quad program sent without quad configuration");

  AST_PROG_LEN: assert property (main_start and is_prog(op)
                                 |-> len != 9'h000 && len <= `PAGE_BYTES)
    else $error("program length outside one to one page");

  AST_SUSP_SECTOR: assert property (main_start and is_prog(op) and erase_suspended_flag
                                    and susp_erase |-> (addr & susp_mask) != susp_base)
    else $error("program aimed at a suspended erase region");

  AST_POLL_AFTER: assert property (write_frame_ends |-> ##[1:16] poll_frame_starts)
    else $error("no busy poll after a write frame");

endmodule

// ==== sim/flash_dev_model.sv ====
// Behavioural flash device: records single-bit frames and answers reads with a fixed nibble.
// Assumes mode-0 pins from the host; quad frames are counted but not decoded.
module flash_dev_model (
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic [3:0]  sio_out,
  input  wire logic [3:0]  sio_oe,
  output logic      [3:0]  sio_in,
  output logic      [31:0] head,
  output logic      [31:0] tail,
  output logic      [31:0] prev,
  output logic      [15:0] bits,
  output logic      [7:0]  frames
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] idle_pat;
  initial
  begin
    {head, prev, tail, bits, frames} = '0;
    idle_pat = 4'h5;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Keep the finished frame so the bench can check frame order
  always @(negedge cs_n)
  begin
    prev = head;
    head = 32'h0;
    tail = 32'h0;
    bits = 16'h0;
    frames = frames + 8'h01;
  end
  // Opcode and address arrive most significant bit first on rising clock edges
  always @(posedge sclk)
    if (!cs_n)
    begin
      if (bits < 16'h20) head = {head[30:0], sio_out[0]};
      tail = {tail[30:0], sio_out[0]};
      bits = bits + 16'h1;
    end
  // Released lines toggle so a stale value never passes for data
  always @(posedge cs_n) idle_pat = ~idle_pat;
  // Answer 9h only while the host has let go of the lines; bit1 low keeps busy clear
  assign sio_in = cs_n ? idle_pat : ((sio_oe == 4'h0) ? 4'h9 : 4'h0);
endmodule

// ==== sim/flash_host_bench.sv ====
// Self-checking bench of the flash host controller over APB with a behavioural flash.
// Assumes the map header on the include path; auto-poll is used only around suspend.
`include "flash_host_map.svh"
module flash_host_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err, cs_n, sclk;
  logic [7:0]  paddr, frames, op;
  logic [31:0] pwdata, prdata, rd, head, prev, tail;
  logic [15:0] bits;
  logic [3:0]  sio_out, sio_oe, sio_in;
  int          failures, checked, cycles;
  logic [7:0]  ops [5] = '{8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60};
  flash_host #(.SUSP_GAP_CYC(50)) flash_host_inst (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cs_n(cs_n), .sclk(sclk), .sio_out(sio_out),
    .sio_oe(sio_oe), .sio_in(sio_in));
  flash_dev_model flash_dev_model_inst (.cs_n(cs_n), .sclk(sclk), .sio_out(sio_out),
    .sio_oe(sio_oe), .sio_in(sio_in), .head(head), .tail(tail), .prev(prev), .bits(bits),
    .frames(frames));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want)
    begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wrap_up;
    if (failures == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One APB transfer; waits for pready with no assumed latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_idle;
    apb(1'b0, `REG_STATUS, 32'h0);
    while (rd[`ST_ACTIVE_BIT] !== 1'b0) apb(1'b0, `REG_STATUS, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic erase_ops;
    apb(1'b1, `REG_ADDR, 32'h0012_3456);
    for (int i = 0; i < 5; i++)
    begin
      op = ops[i];
      apb(1'b1, `REG_CMD, {24'h0, op});
      wait_idle();
      check(prev, 32'h06);
      check(head, (i < 3) ? {op, 24'h12_3456} : {24'h0, op});
      check(bits, (i < 3) ? 16'h20 : 16'h8);
    end
  endtask
  // Suspend right after an unpolled chip erase, then illegal programs and resume
  task automatic refusals;
    logic [7:0] f0;
    f0 = frames;
    apb(1'b1, `REG_CMD, 32'hb0);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rd[`ST_REFUSED_BIT], 1'b1);
    apb(1'b1, `REG_LEN, 32'h0);
    apb(1'b1, `REG_CMD, 32'h02);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rd[`ST_REFUSED_BIT], 1'b1);
    apb(1'b1, `REG_LEN, 32'h1);
    apb(1'b1, `REG_CMD, 32'h32);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rd[`ST_REFUSED_BIT], 1'b1);
    apb(1'b1, `REG_CMD, 32'h30);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rd[`ST_REFUSED_BIT], 1'b1);
    check(frames, f0);
  endtask
  // Polled erase, suspend, refused program and second suspend, then resume
  task automatic suspend_resume;
    logic [7:0] f0;
    apb(1'b1, `REG_CMD, 32'h220);
    wait_idle();
    check(prev, 32'h2012_3456);
    check(head, 32'h0500);
    apb(1'b1, `REG_CMD, 32'h2b0);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rd[`ST_GAP_BIT], 1'b1);
    wait_idle();
    check(prev, 32'hb0);
    check(rd[`ST_SUSPENDED_BIT], 1'b1);
    f0 = frames;
    apb(1'b1, `REG_LEN, 32'h1);
    apb(1'b1, `REG_CMD, 32'h02);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rd[`ST_REFUSED_BIT], 1'b1);
    apb(1'b1, `REG_CMD, 32'hb0);
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rd[`ST_REFUSED_BIT], 1'b1);
    check(frames, f0);
    apb(1'b1, `REG_CMD, 32'h230);
    wait_idle();
    check(prev, 32'h30);
    check(rd[`ST_SUSPENDED_BIT], 1'b0);
  endtask
  // Quad identification read; the model answers 9h on every nibble
  task automatic id_read;
    apb(1'b1, `REG_CMD, 32'haf);
    wait_idle();
    check(bits, 16'h000a);
    check(head, 32'h0100);
    apb(1'b0, `REG_RDATA, 32'h0);
    check(rd, 32'h0099_9999);
  endtask
  task automatic page_prog;
    apb(1'b1, `REG_LEN, 32'h2);
    apb(1'b1, `REG_WDATA, 32'ha5);
    apb(1'b1, `REG_WDATA, 32'h3c);
    apb(1'b1, `REG_ADDR, 32'h0000_0100);
    apb(1'b1, `REG_CMD, 32'h02);
    wait_idle();
    check(head, 32'h0200_0100);
    check(bits, 16'h30);
    check(tail, 32'h0100_a53c);
    check(prev, 32'h06);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      failures++;
      wrap_up();
    end
  end
  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    apb(1'b0, 8'h40, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, `REG_CMD, 32'h06);
    wait_idle();
    check(head, 32'h06);
    check(bits, 16'h8);
    erase_ops();
    refusals();
    suspend_resume();
    page_prog();
    id_read();
    wrap_up();
  end
endmodule
